// >>> longitudinal_timecode_generator.sv
`timescale 1ns/1ps
// What this block does
// - Five sixteen-bit code words, write only
// - Send 80 bits bi-phase mark per frame
// - Reference falling edge starts next frame
// - Two banks: host fills one, other sends
// - Low pulse when a bank is free
// - Missed flag on frame without data
// - Sync word write commits the data set
// - Synchronous mode: qualifier gates each write
// - Asynchronous mode: rising edge captures write
// - Time groups at words zero to three
// - Standard select picks PAL or NTSC timing
// - Enable takes effect at next frame, disable stops output at once
// - Bit timing from 27 MHz video rate
module longitudinal_timecode_generator
    import ltc_pkg::*;
#(
    parameter logic [HALF_W-1:0] HALF_PAL = HALF_W'(HALF_BIT_PAL_CNT),
    parameter logic [HALF_W-1:0] HALF_NTSC = HALF_W'(HALF_BIT_NTSC_CNT)
) (
    input wire logic core_clk_i, // System clock
    input wire logic rst_i, // Sync reset, high
    input wire logic host_write_clock_i, // Host write clock pin
    input wire logic host_write_qualifier_i, // Write enable / chip select
    input wire logic [SEL_W-1:0] host_word_select_i, // Word select
    input wire logic [WORD_W-1:0] host_write_bus_i, // Write data
    output logic host_write_ready_o, // Write FIFO has room
    input wire logic frame_reference_i, // Frame start, falling edge
    input wire logic broadcast_standard_select_i, // 1 PAL, 0 NTSC
    input wire logic code_output_enable_i, // Transmission enable
    output logic code_serial_out_o, // Encoded code stream
    output logic frame_request_n_o, // Bank free pulse, low
    output logic data_missed_flag_o // Underrun status
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] pins;
    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;
    logic wclk_prev_reg;
    logic ref_prev_reg;
    logic en_s;
    logic std_s;

    assign pins = {host_write_clock_i, host_write_qualifier_i, host_word_select_i,
                   host_write_bus_i, frame_reference_i, broadcast_standard_select_i,
                   code_output_enable_i};
    assign en_s = sync_reg[PIN_EN];
    assign std_s = sync_reg[PIN_STD];

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
            wclk_prev_reg <= 1'b0;
            ref_prev_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
            wclk_prev_reg <= sync_reg[PIN_WCLK];
            ref_prev_reg <= sync_reg[PIN_REF];
        end
    end

    // ------------------------------------------------------------
    // Host write capture and FIFO
    // ------------------------------------------------------------
    logic host_write;
    logic ref_fall;
    logic fifo_valid;
    logic [FIFO_W-1:0] fifo_data;
    logic drain_ready;
    logic fire;
    logic [SEL_W-1:0] f_sel;
    logic ram_we;
    logic commit;
    tx_state_t state_reg;

    // Same sampled edge serves a free-running clock or a write strobe
    assign host_write = sync_reg[PIN_WCLK] && !wclk_prev_reg
                        && sync_reg[PIN_QUAL];
    assign ref_fall = !sync_reg[PIN_REF] && ref_prev_reg;

    code_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .in_valid_i(host_write),
        .in_ready_o(host_write_ready_o),
        .in_data_i(sync_reg[PIN_QUAL-1:PIN_DATA]),
        .out_valid_o(fifo_valid),
        .out_ready_i(drain_ready),
        .out_data_o(fifo_data)
    );

    // Drain stalls while a bank is read out and on a reference fall, so commit never meets a swap
    assign drain_ready = (state_reg != ST_LOAD) && !ref_fall;
    assign fire = fifo_valid && drain_ready;
    assign f_sel = fifo_data[FIFO_W-1:WORD_W];
    assign ram_we = fire && (f_sel <= SEL_SYNC);
    assign commit = fire && (f_sel == SEL_SYNC);

    // ------------------------------------------------------------
    // Double buffer banks
    // ------------------------------------------------------------
    logic pending_reg;
    logic wr_bank_reg;
    logic tx_bank_reg;
    logic start;
    logic swap;
    logic [SEL_W-1:0] load_idx_reg;
    logic [WORD_W-1:0] rdata;

    assign start = ref_fall && en_s;
    assign swap = start && pending_reg;

    // No host read port: the banks are write only from the host side
    word_buffer_ram #(
        .AW(BANK_AW),
        .DW(WORD_W)
    ) u_ram (
        .core_clk_i(core_clk_i),
        .we_i(ram_we),
        .waddr_i({wr_bank_reg, f_sel}),
        .wdata_i(fifo_data[WORD_W-1:0]),
        .raddr_i({tx_bank_reg, load_idx_reg}),
        .rdata_o(rdata)
    );

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            pending_reg <= 1'b0;
            wr_bank_reg <= 1'b0;
            tx_bank_reg <= 1'b1;
        end
        else if (commit)
        begin
            pending_reg <= 1'b1;
        end
        else if (swap)
        begin
            pending_reg <= 1'b0;
            wr_bank_reg <= !wr_bank_reg;
            tx_bank_reg <= wr_bank_reg;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            frame_request_n_o <= 1'b1;
        end
        else
        begin
            frame_request_n_o <= !swap;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || !en_s)
        begin
            data_missed_flag_o <= 1'b0;
        end
        else if (start && !pending_reg)
        begin
            data_missed_flag_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Video rate tick
    // ------------------------------------------------------------
    // Fractional step keeps the 27 MHz rate exact on average
    logic [6:0] acc_reg;
    logic [6:0] acc_sum;
    logic tick;

    assign acc_sum = acc_reg + TICK_STEP;
    assign tick = acc_sum >= TICK_WRAP;

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            acc_reg <= '0;
        end
        else
        begin
            acc_reg <= tick ? acc_sum - TICK_WRAP : acc_sum;
        end
    end

    // ------------------------------------------------------------
    // Transmit state machine
    // ------------------------------------------------------------
    logic rd_valid_reg;
    logic [SEL_W-1:0] cap_cnt_reg;
    logic [HALF_W-1:0] half_cnt_reg;
    logic [HALF_W-1:0] half_len;
    logic half_phase_reg;
    logic [6:0] bit_idx_reg;
    logic [CODE_BITS-1:0] word_reg;
    logic load_done;
    logic half_end;
    logic bit_end;
    logic last_bit;

    assign half_len = std_s ? HALF_PAL : HALF_NTSC;
    assign load_done = (state_reg == ST_LOAD) && rd_valid_reg
                       && (cap_cnt_reg == LAST_LOAD_IDX);
    assign half_end = (state_reg == ST_SEND) && tick
                      && (half_cnt_reg == half_len - 1'b1);
    assign bit_end = half_end && half_phase_reg;
    assign last_bit = bit_end && (bit_idx_reg == LAST_BIT);

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || !en_s)
        begin
            state_reg <= ST_IDLE;
        end
        else if (start)
        begin
            state_reg <= ST_LOAD;
        end
        else
        begin
            case (state_reg)
                ST_LOAD: if (load_done) state_reg <= ST_SEND;
                ST_SEND: if (last_bit) state_reg <= ST_WAIT;
                ST_IDLE, ST_WAIT: state_reg <= state_reg;
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Words enter from the top so word zero ends at bit zero, sent first
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || start)
        begin
            load_idx_reg <= '0;
            rd_valid_reg <= 1'b0;
            cap_cnt_reg <= '0;
        end
        else if (state_reg == ST_LOAD)
        begin
            rd_valid_reg <= load_idx_reg <= LAST_LOAD_IDX;
            if (load_idx_reg <= LAST_LOAD_IDX)
            begin
                load_idx_reg <= load_idx_reg + 1'b1;
            end
            if (rd_valid_reg)
            begin
                cap_cnt_reg <= cap_cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || !en_s)
        begin
            word_reg <= '0;
            code_serial_out_o <= 1'b0;
            half_cnt_reg <= '0;
            half_phase_reg <= 1'b0;
            bit_idx_reg <= '0;
        end
        else if (state_reg == ST_LOAD && !start)
        begin
            if (rd_valid_reg)
            begin
                word_reg <= {rdata, word_reg[CODE_BITS-1:WORD_W]};
            end
            if (load_done)
            begin
                code_serial_out_o <= !code_serial_out_o;
                half_cnt_reg <= '0;
                half_phase_reg <= 1'b0;
                bit_idx_reg <= '0;
            end
        end
        else if (state_reg == ST_SEND && tick)
        begin
            half_cnt_reg <= half_end ? '0 : half_cnt_reg + 1'b1;
            if (half_end)
            begin
                half_phase_reg <= !half_phase_reg;
                if (!half_phase_reg && word_reg[0])
                begin
                    code_serial_out_o <= !code_serial_out_o;
                end
                if (bit_end)
                begin
                    word_reg <= {1'b0, word_reg[CODE_BITS-1:1]};
                    bit_idx_reg <= bit_idx_reg + 1'b1;
                    if (!last_bit)
                    begin
                        code_serial_out_o <= !code_serial_out_o;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_req_pulse;
        @(posedge core_clk_i) disable iff (rst_i) !frame_request_n_o |=> frame_request_n_o;
    endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("request pulse too long");

    property p_req_on_swap;
        @(posedge core_clk_i) disable iff (rst_i) swap |=> !frame_request_n_o && !pending_reg;
    endproperty
    a_req_on_swap: assert property (p_req_on_swap) else $error("no request after swap");

    property p_missed_set;
        @(posedge core_clk_i) disable iff (rst_i) start && !pending_reg |=> data_missed_flag_o;
    endproperty
    a_missed_set: assert property (p_missed_set) else $error("underrun not flagged");

    property p_missed_clr;
        @(posedge core_clk_i) disable iff (rst_i) !en_s |=> !data_missed_flag_o;
    endproperty
    a_missed_clr: assert property (p_missed_clr) else $error("underrun not cleared");

    property p_idle_out;
        @(posedge core_clk_i) disable iff (rst_i) !en_s |=> !code_serial_out_o;
    endproperty
    a_idle_out: assert property (p_idle_out) else $error("output active while off");

    property p_start_load;
        @(posedge core_clk_i) disable iff (rst_i) start |=> state_reg == ST_LOAD;
    endproperty
    a_start_load: assert property (p_start_load) else $error("frame edge ignored");

    property p_load_len;
        @(posedge core_clk_i) disable iff (rst_i || !en_s || ref_fall)
            start ##1 (!ref_fall)[*6] |=> state_reg == ST_SEND;
    endproperty
    a_load_len: assert property (p_load_len) else $error("load not done in six cycles");

    property p_ignore_sel;
        @(posedge core_clk_i) disable iff (rst_i) fire && (f_sel > SEL_SYNC) |-> !ram_we;
    endproperty
    a_ignore_sel: assert property (p_ignore_sel) else $error("high select written");

    property p_commit;
        @(posedge core_clk_i) disable iff (rst_i) commit |=> pending_reg;
    endproperty
    a_commit: assert property (p_commit) else $error("sync write did not commit");

    property p_bank_flip;
        @(posedge core_clk_i) disable iff (rst_i)
            swap |=> wr_bank_reg != $past(wr_bank_reg) && tx_bank_reg == $past(wr_bank_reg);
    endproperty
    a_bank_flip: assert property (p_bank_flip) else $error("banks not exchanged");

    property p_bit_edge;
        @(posedge core_clk_i) disable iff (rst_i || !en_s)
            bit_end && !last_bit && !start |=> code_serial_out_o != $past(code_serial_out_o);
    endproperty
    a_bit_edge: assert property (p_bit_edge) else $error("no transition at bit start");

    c_swap: cover property (@(posedge core_clk_i) disable iff (rst_i) swap);
    c_missed: cover property (@(posedge core_clk_i) disable iff (rst_i) $rose(data_missed_flag_o));
    c_full: cover property (@(posedge core_clk_i) disable iff (rst_i) !host_write_ready_o);
    c_frame_done: cover property (@(posedge core_clk_i) disable iff (rst_i) last_bit);
endmodule : longitudinal_timecode_generator

// >>> ltc_pkg.sv
// ----------------------------------------------------------------
// Shared constants of the time code generator
// ----------------------------------------------------------------
package ltc_pkg;

    localparam int WORD_W = 16;
    localparam int WORDS = 5;
    localparam int CODE_BITS = 80;
    localparam int SEL_W = 3;
    localparam int BANK_AW = 4;

    // Word select of each code word (byte address / 2)
    localparam logic [SEL_W-1:0] SEL_FRAMES = 3'h0;
    localparam logic [SEL_W-1:0] SEL_SECONDS = 3'h1;
    localparam logic [SEL_W-1:0] SEL_MINUTES = 3'h2;
    localparam logic [SEL_W-1:0] SEL_HOURS = 3'h3;
    localparam logic [SEL_W-1:0] SEL_SYNC = 3'h4;
    localparam logic [SEL_W-1:0] LAST_LOAD_IDX = 3'h4;

    localparam logic [15:0] SYNC_WORD_VALUE = 16'hbffc;

    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = SEL_W + WORD_W;

    // Two-flop pin bundle layout
    localparam int SYNC_W = 24;
    localparam int PIN_EN = 0;
    localparam int PIN_STD = 1;
    localparam int PIN_REF = 2;
    localparam int PIN_DATA = 3;
    localparam int PIN_SEL = 19;
    localparam int PIN_QUAL = 22;
    localparam int PIN_WCLK = 23;

    // Rates and frame periods
    localparam int CORE_CLK_MHZ = 50;
    localparam int VIDEO_CLK_MHZ = 27;
    localparam logic [6:0] TICK_STEP = 7'h1b;
    localparam logic [6:0] TICK_WRAP = 7'h32;
    localparam int FRAME_NS_PAL = 40000000;
    localparam int FRAME_NS_NTSC = 33366667;
    localparam int HALF_W = 14;
    localparam int HALF_BIT_PAL_CNT = FRAME_NS_PAL / 1000 * VIDEO_CLK_MHZ / (2 * CODE_BITS);
    localparam int HALF_BIT_NTSC_CNT = FRAME_NS_NTSC / 1000 * VIDEO_CLK_MHZ / (2 * CODE_BITS);
    localparam logic [6:0] LAST_BIT = 7'h4f;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LOAD = 4'h2,
        ST_SEND = 4'h4,
        ST_WAIT = 4'h8
    } tx_state_t;

endpackage : ltc_pkg

// >>> code_fifo.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host write FIFO
// ----------------------------------------------------------------
module code_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 8
) (
    input wire logic core_clk_i, // System clock
    input wire logic rst_i, // Sync reset, high
    input wire logic in_valid_i, // Write offered
    output logic in_ready_o, // Not full
    input wire logic [WIDTH-1:0] in_data_i, // Write data
    output logic out_valid_o, // Not empty
    input wire logic out_ready_i, // Drain accepts
    output logic [WIDTH-1:0] out_data_o // Head entry
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic push;
    logic pop;

    assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
    assign in_ready_o = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0])
                        || (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_reg[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge core_clk_i)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule : code_fifo

// >>> word_buffer_ram.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two banks of code words, registered read
// ----------------------------------------------------------------
module word_buffer_ram #(
    parameter int AW = 4,
    parameter int DW = 16
) (
    input wire logic core_clk_i, // System clock
    input wire logic we_i, // Write strobe
    input wire logic [AW-1:0] waddr_i, // Write address
    input wire logic [DW-1:0] wdata_i, // Write data
    input wire logic [AW-1:0] raddr_i, // Read address
    output logic [DW-1:0] rdata_o // Read data, one cycle late
);
    logic [DW-1:0] mem_reg [2**AW];

    always_ff @(posedge core_clk_i)
    begin
        if (we_i)
        begin
            mem_reg[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_reg[raddr_i];
    end
endmodule : word_buffer_ram

// >>> host_cpu_model.sv
`timescale 1ns/1ps
// ------------------------------
// Host writing code word sets
// ------------------------------
module host_cpu_model (
    input wire logic core_clk_i, // System clock
    input wire logic start_i, // Begin a set
    input wire logic slow_i, // Long strobe phases
    input wire logic junk_i, // Add writes to drop
    input wire logic [63:0] code_i, // Words 0..3
    input wire logic host_write_ready_i, // Room
    output logic host_write_clock_o, // Strobe
    output logic host_write_qualifier_o, // Select
    output logic [2:0] host_word_select_o, // Word
    output logic [15:0] host_write_bus_o, // Data
    output logic done_o // Set complete
);
    initial
    begin
        host_write_clock_o = 1'b0;
        host_write_qualifier_o = 1'b0;
        host_word_select_o = 3'h0;
        host_write_bus_o = 16'h0000;
        done_o = 1'b1;
    end

    task automatic put(input logic [2:0] sel, input logic [15:0] d, input logic q);
        int n;
        int k;
        n = slow_i ? 10 : 3;
        for (k = 0; k < 500 && host_write_ready_i !== 1'b1; k++)
            @(posedge core_clk_i);
        @(posedge core_clk_i);
        #1;
        host_word_select_o = sel;
        host_write_bus_o = d;
        host_write_qualifier_o = q;
        repeat (n) @(posedge core_clk_i);
        #1;
        host_write_clock_o = 1'b1;
        repeat (n) @(posedge core_clk_i);
        #1;
        host_write_clock_o = 1'b0;
        repeat (n) @(posedge core_clk_i);
        #1;
        host_write_qualifier_o = 1'b0;
        // Stale data inverted so it never reads as held
        host_write_bus_o = ~d;
    endtask : put

    always
    begin : seq
        int i;
        @(posedge start_i);
        done_o = 1'b0;
        for (i = 0; i < 4; i++)
        begin
            put(3'(i), code_i[16*i +: 16], 1'b1);
            if (i == 0 && junk_i)
            begin
                put(3'h5, 16'hffff, 1'b1);
                put(3'h7, 16'hffff, 1'b1);
                put(3'h0, 16'hffff, 1'b0);
            end
        end
        put(3'h4, 16'hbffc, 1'b1);
        done_o = 1'b1;
    end
endmodule : host_cpu_model

// >>> tb_longitudinal_timecode_generator.sv
`timescale 1ns/1ps
// ------------------------------
// Bench
// ------------------------------
module tb_longitudinal_timecode_generator;
    import ltc_pkg::*;
    localparam int HP = 4;
    localparam int HN = 6;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ref_in = 1'b1;
    logic std_sel = 1'b1;
    logic out_en = 1'b0;
    logic start = 1'b0;
    logic slow = 1'b0;
    logic junk = 1'b0;
    logic [63:0] code = '0;
    logic hclk, hqual, done, ready, ser, req_n, missed;
    logic [2:0] hsel;
    logic [15:0] hbus;
    logic armed = 1'b0;
    logic started, half;
    logic prev = 1'b0;
    logic [79:0] rx;
    int cnt, nb, span;
    int miscompares = 0;
    int n_tests = 0;
    logic [63:0] a, b, d;

    longitudinal_timecode_generator #(.HALF_PAL(HALF_W'(HP)), .HALF_NTSC(HALF_W'(HN))) uut (
        .core_clk_i(clk), .rst_i(rst), .host_write_clock_i(hclk),
        .host_write_qualifier_i(hqual), .host_word_select_i(hsel),
        .host_write_bus_i(hbus), .host_write_ready_o(ready),
        .frame_reference_i(ref_in), .broadcast_standard_select_i(std_sel),
        .code_output_enable_i(out_en), .code_serial_out_o(ser),
        .frame_request_n_o(req_n), .data_missed_flag_o(missed));
    host_cpu_model host (.core_clk_i(clk), .start_i(start), .slow_i(slow),
        .junk_i(junk), .code_i(code), .host_write_ready_i(ready),
        .host_write_clock_o(hclk), .host_write_qualifier_o(hqual),
        .host_word_select_o(hsel), .host_write_bus_o(hbus), .done_o(done));

    initial
    begin
        forever #10 clk = ~clk;
    end

    // Bi-phase mark decode by transition spacing, last bit by silence
    always @(negedge clk)
    begin : dec
        int hc;
        hc = (std_sel ? HP : HN) * 50 / 27;
        if (armed)
        begin
            cnt++;
            if (ser !== prev)
            begin
                if (!started)
                    started = 1'b1;
                else if (cnt < hc * 3 / 2)
                begin
                    if (half)
                    begin
                        rx[nb] = 1'b1;
                        nb++;
                    end
                    half = ~half;
                end
                else
                begin
                    rx[nb] = 1'b0;
                    nb++;
                end
                cnt = 0;
            end
            else if (started && cnt == 3 * hc)
            begin
                rx[nb] = half;
                armed = 1'b0;
            end
            if (started && nb < 79)
                span++;
        end
        prev = ser;
    end

    task automatic report_and_stop;
        $display("Comparisons %0d, errors %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk_bit(input logic g, input logic e, input string w);
        n_tests++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error at %0t: %s got %b want %b", $time, w, g, e);
        end
    endtask : chk_bit

    task automatic chk_int(input int g, input int e, input int tol, input string w);
        n_tests++;
        if (g > e + tol || g < e - tol)
        begin
            miscompares++;
            $display("Error at %0t: %s got %0d want %0d", $time, w, g, e);
        end
    endtask : chk_int

    task automatic chk_code(input logic [79:0] g, input logic [79:0] e);
        n_tests++;
        if (g !== e)
        begin
            miscompares++;
            $display("Error at %0t: code got %h want %h", $time, g, e);
        end
    endtask : chk_code

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    function automatic logic [63:0] mk(input logic [3:0] fu, input logic pal);
        logic [63:0] c;
        int i;
        c = {16'h0102, 16'h0304, 16'h0205, 12'h000, fu};
        i = pal ? 59 : 27;
        c[i] = 1'b0;
        if ((80 - $countones({16'hbffc, c})) % 2 != 0)
            c[i] = 1'b1;
        return c;
    endfunction : mk

    task automatic write_set(input logic [63:0] c, input logic s, input logic j);
        int k;
        code = c;
        slow = s;
        junk = j;
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        for (k = 0; k < 3000 && !done; k++)
            cyc(1);
        chk_bit(done, 1'b1, "host set done");
    endtask : write_set

    task automatic frame(input int er, input logic em, input logic ck, input logic [79:0] e);
        int r;
        int k;
        r = 0;
        started = 1'b0;
        half = 1'b0;
        nb = 0;
        cnt = 0;
        span = 0;
        armed = 1'b1;
        ref_in = 1'b0;
        for (k = 0; k < 12; k++)
        begin
            cyc(1);
            if (req_n === 1'b0)
                r++;
        end
        chk_int(r, er, 0, "request pulses");
        chk_bit(missed, em, "missed flag");
        if (ck)
        begin
            for (k = 0; k < 4000 && armed; k++)
                cyc(1);
            chk_code(rx, e);
            chk_int(span, 158 * (std_sel ? HP : HN) * 50 / 27, 4, "span");
        end
        ref_in = 1'b1;
        cyc(20);
    endtask : frame

    initial
    begin
        repeat (40000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end

    initial
    begin
        cyc(16);
        rst = 1'b0;
        cyc(8);
        chk_bit(ser, 1'b0, "idle out");
        chk_bit(req_n, 1'b1, "request idle");
        chk_bit(missed, 1'b0, "missed idle");
        chk_bit(ready, 1'b1, "ready");
        out_en = 1'b1;
        cyc(60);
        chk_bit(ser, 1'b0, "mid-frame enable");
        frame(0, 1'b1, 1'b0, '0);
        out_en = 1'b0;
        cyc(6);
        armed = 1'b0;
        chk_bit(missed, 1'b0, "missed cleared");
        chk_bit(ser, 1'b0, "disabled out");
        a = mk(4'h1, 1'b1);
        b = mk(4'h2, 1'b1);
        d = mk(4'h3, 1'b0);
        write_set(a, 1'b0, 1'b0);
        out_en = 1'b1;
        cyc(20);
        fork
            frame(1, 1'b0, 1'b1, {16'hbffc, a});
            begin
                cyc(200);
                write_set(b, 1'b0, 1'b1);
            end
        join
        frame(1, 1'b0, 1'b1, {16'hbffc, b});
        frame(0, 1'b1, 1'b1, {16'hbffc, b});
        out_en = 1'b0;
        std_sel = 1'b0;
        cyc(6);
        chk_bit(missed, 1'b0, "missed cleared");
        write_set(d, 1'b1, 1'b0);
        out_en = 1'b1;
        cyc(20);
        frame(1, 1'b0, 1'b1, {16'hbffc, d});
        report_and_stop();
    end
endmodule : tb_longitudinal_timecode_generator
